/* File: rtl/tfoc_pkg.sv */
/*
   Constants and types for the time frame output controller.
   Assumes a single 25 MHz clock and an AHB-Lite register bus.
*/
package tfoc_pkg;
   // ============================================================
   // Timing
   localparam int CLK_NS = 40;
   localparam int BASE_NS = 10000;
   localparam int BASE_CYC = (BASE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_NS = 100;
   localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
   // ============================================================
   // Register map, byte offsets
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_FRAME = 8'h08;
   localparam logic [7:0] OFS_CYCLE = 8'h0c;
   localparam logic [7:0] OFS_IRQ = 8'h10;
   localparam int MEM_SEL_BIT = 14;
   // ============================================================
   // Status fields
   localparam int ST_GO_EN = 0;
   localparam int ST_HOLD_EN = 1;
   localparam int ST_IRQ_LSB = 4;
   localparam int ST_RUN = 8;
   localparam int ST_PAUSED = 9;
   localparam int ST_LIVE = 10;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [11:0] CYCLE_RST = 12'h000;
   // Command bits
   localparam int CMD_START = 0;
   localparam int CMD_PAUSE = 1;
   localparam int CMD_INIT = 2;
   // Interrupt events, same layout as the enable field
   localparam int EV_RUN_END = 0;
   localparam int EV_PAUSE = 1;
   localparam int EV_CYCLE = 2;
   localparam int EV_FRAME = 3;
   // Frame memory words
   localparam int TW_RATE_LSB = 10;
   localparam int PW_PAUSE = 14;
   localparam int PW_EOL = 15;
   // ============================================================
   // Types
   typedef enum logic [2:0] {S_IDLE, S_RD_T, S_RD_P, S_LOAD, S_HOLD, S_RUN, S_PAUSE} tfoc_seq_t;
   typedef enum logic [1:0] {B_IDLE, B_ACC, B_MRD} tfoc_bus_t;
endpackage

/* File: rtl/tfoc_mem_if.sv */
/*
   Port between the controller and its frame memory.
   Assumes one access per cycle, read data one cycle later.
*/
`timescale 1ns/1ps
interface tfoc_mem_if;
   logic we;
   logic [11:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   modport user (output we, output addr, output wdata, input rdata);
   modport store (input we, input addr, input wdata, output rdata);
endinterface

/* File: rtl/tfoc_frame_mem.sv */
/*
   Frame memory, 4096 words of 16 bits, single port.
   Assumes the user arbitrates; read data lags the address by one cycle.
*/
`timescale 1ns/1ps
module tfoc_frame_mem (
   // Clock
   input wire logic clock_i,
   // Memory port
   tfoc_mem_if.store mem
);
   logic [15:0] store_arr [0:4095];

   always_ff @(posedge clock_i) begin
      if (mem.we) begin
         store_arr[mem.addr] <= mem.wdata;
      end
      mem.rdata <= store_arr[mem.addr];
   end
endmodule

/* File: rtl/tfoc_sync.sv */
/*
   Two-flop synchronisers for the external go and hold pins.
   Assumes the pins idle high and are pulled low to signal.
*/
`timescale 1ns/1ps
module tfoc_sync (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_n_i,
   // Pins and synchronised levels
   input wire logic [1:0] pin_i,
   output logic [1:0] level_o
);
   logic [1:0] meta_reg;

   for (genvar i = 0; i < 2; i++) begin : g_bit
      always_ff @(posedge clock_i) begin
         if (!rst_n_i) begin
            meta_reg[i] <= 1'b1;
            level_o[i] <= 1'b1;
         end else begin
            meta_reg[i] <= pin_i[i];
            level_o[i] <= meta_reg[i];
         end
      end
   end
endmodule

/* File: rtl/tfoc_top.sv */
/*
   Time frame output controller: frame sequencer, output latches, AHB-Lite
   register slave and interrupt logic. Assumes a single 25 MHz clock,
   one AHB master doing single word transfers, and asynchronous pins.
*/
// Notes on behaviour
// - Gate output is high while counting is allowed, low to stop it.
// - The initialise command clears the status register.
// - Initialise during a run stops the sequence early and returns to idle.
// - Frame number stays stable a hold interval after gate drops.
// - Cycle writes go to a latch, loaded at run start; reads give counter.
// - Cycle count takes values 0 to 4095.
// - Frame memory offers 4096 host-accessible 16-bit words.
// - Status bits 0 and 1 enable the external inputs.
// - Interrupt enable bits live in the status register.
// - Cleared enable bits make the external go and hold inputs ignored.
// - Host pause command pauses frame timing until a new start.
// - When enabled, a falling edge on external go acts as start.
// - When enabled, a falling edge on external hold pauses the sequence.
// - Start begins from idle or resumes the current frame from pause.
// - Host can read the current frame number at any time.
// - Lap end: nonzero counter decrements, frame resets; zero counter ends run.
// - Idle asserts inhibit and zeroes frame number and output port.
`timescale 1ns/1ps
module tfoc_top
   import tfoc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   // AHB-Lite slave
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   // External pins, active low edges
   input wire logic EXTERNAL_GO_IN_I,
   input wire logic EXTERNAL_HOLD_IN_I,
   // Acquisition outputs
   output logic [9:0] FRAME_O,
   output logic GATE_O,
   output logic XFER_O,
   output logic [7:0] PORT_O,
   // Interrupt
   output logic IRQ_O
);
   // ============================================================
   // Declarations
   tfoc_seq_t state_reg;
   tfoc_bus_t bstate_reg;
   tfoc_mem_if mem ();
   logic [1:0] pin_lvl;
   logic [1:0] pin_prev_reg;
   logic go_edge;
   logic hold_edge;
   logic [14:0] ap_addr_reg;
   logic ap_write_reg;
   logic ap_is_mem;
   logic seq_mem_use;
   logic acc_reg_wr;
   logic acc_reg_rd;
   logic cmd_start;
   logic cmd_pause;
   logic cmd_init;
   logic start_any;
   logic pause_any;
   logic [7:0] status_reg;
   logic [11:0] cyc_latch_reg;
   logic [11:0] cyc_cnt_reg;
   logic [3:0] irq_pend_reg;
   logic [3:0] ev_reg;
   logic [9:0] addr_frame_reg;
   logic half_reg;
   logic [15:0] time_word_reg;
   logic [15:0] port_word_reg;
   logic [7:0] hold_cnt_reg;
   logic to_idle_reg;
   logic pause_pend_reg;
   logic [7:0] presc_reg;
   logic [23:0] unit_reg;
   logic [9:0] cnt_reg;
   logic tick;
   logic unit_wrap;
   logic frame_done;
   logic [31:0] reg_rd;

   // ============================================================
   // Helpers
   function automatic logic reg_hit(input logic [14:0] a, input logic [7:0] ofs);
      return !a[MEM_SEL_BIT] && (a[13:0] == {6'h00, ofs});
   endfunction

   // Time units step by decades from the base tick
   function automatic logic [23:0] units_of(input logic [2:0] rate);
      logic [23:0] v;
      v = 24'h000001;
      for (int i = 0; i < 7; i++) begin
         if (i < int'(rate)) begin
            v = 24'(v * 24'd10);
         end
      end
      return v;
   endfunction

   // ============================================================
   // External inputs
   tfoc_sync u_sync (
      .clock_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .pin_i({EXTERNAL_HOLD_IN_I, EXTERNAL_GO_IN_I}),
      .level_o(pin_lvl)
   );

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         pin_prev_reg <= 2'h3;
      end else begin
         pin_prev_reg <= pin_lvl;
      end
   end

   assign go_edge = status_reg[ST_GO_EN] && pin_prev_reg[0] && !pin_lvl[0];
   assign hold_edge = status_reg[ST_HOLD_EN] && pin_prev_reg[1] && !pin_lvl[1];

   // ============================================================
   // Bus decode
   assign ap_is_mem = ap_addr_reg[MEM_SEL_BIT];
   assign seq_mem_use = (state_reg == S_RD_T) || (state_reg == S_RD_P);
   assign acc_reg_wr = (bstate_reg == B_ACC) && ap_write_reg && !ap_is_mem;
   assign acc_reg_rd = (bstate_reg == B_ACC) && !ap_write_reg && !ap_is_mem;
   assign cmd_start = acc_reg_wr && reg_hit(ap_addr_reg, OFS_CMD) && HWDATA_I[CMD_START];
   assign cmd_pause = acc_reg_wr && reg_hit(ap_addr_reg, OFS_CMD) && HWDATA_I[CMD_PAUSE];
   assign cmd_init = acc_reg_wr && reg_hit(ap_addr_reg, OFS_CMD) && HWDATA_I[CMD_INIT];
   assign start_any = cmd_start || go_edge;
   assign pause_any = cmd_pause || hold_edge || pause_pend_reg;

   always_comb begin
      reg_rd = 32'h0000_0000;
      if (reg_hit(ap_addr_reg, OFS_STATUS)) begin
         reg_rd[7:0] = status_reg;
         reg_rd[ST_RUN] = (state_reg != S_IDLE);
         reg_rd[ST_PAUSED] = (state_reg == S_PAUSE);
         reg_rd[ST_LIVE] = GATE_O;
      end else if (reg_hit(ap_addr_reg, OFS_FRAME)) begin
         reg_rd[9:0] = FRAME_O;
      end else if (reg_hit(ap_addr_reg, OFS_CYCLE)) begin
         reg_rd[11:0] = cyc_cnt_reg;
      end else if (reg_hit(ap_addr_reg, OFS_IRQ)) begin
         reg_rd[ST_IRQ_LSB +: 4] = irq_pend_reg;
      end
   end

   // ============================================================
   // Frame memory, sequencer fetches take priority over the bus
   assign mem.addr = seq_mem_use ? {addr_frame_reg, half_reg, state_reg == S_RD_P} : ap_addr_reg[13:2];
   assign mem.we = (bstate_reg == B_ACC) && ap_is_mem && ap_write_reg && !seq_mem_use;
   assign mem.wdata = HWDATA_I[15:0];

   tfoc_frame_mem u_mem (
      .clock_i(CLOCK_I),
      .mem(mem.store)
   );

   // ============================================================
   // AHB-Lite slave; every transfer gets at least one wait state
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         bstate_reg <= B_IDLE;
         ap_addr_reg <= 15'h0000;
         ap_write_reg <= 1'b0;
         HREADYOUT_O <= 1'b1;
         HRDATA_O <= 32'h0000_0000;
         HRESP_O <= 1'b0;
      end else begin
         unique case (bstate_reg)
            B_IDLE: begin
               if (HSEL_I && HTRANS_I[1] && HREADY_I) begin
                  ap_addr_reg <= HADDR_I[14:0];
                  ap_write_reg <= HWRITE_I;
                  HREADYOUT_O <= 1'b0;
                  bstate_reg <= B_ACC;
               end
            end
            B_ACC: begin
               if (ap_is_mem && seq_mem_use) begin
                  bstate_reg <= B_ACC;
               end else if (ap_is_mem && !ap_write_reg) begin
                  bstate_reg <= B_MRD;
               end else begin
                  HRDATA_O <= ap_write_reg ? 32'h0000_0000 : reg_rd;
                  HREADYOUT_O <= 1'b1;
                  bstate_reg <= B_IDLE;
               end
            end
            B_MRD: begin
               HRDATA_O <= {16'h0000, mem.rdata};
               HREADYOUT_O <= 1'b1;
               bstate_reg <= B_IDLE;
            end
         endcase
      end
   end

   // ============================================================
   // Status and cycle latch
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I || cmd_init) begin
         status_reg <= STATUS_RST;
      end else if (acc_reg_wr && reg_hit(ap_addr_reg, OFS_STATUS)) begin
         status_reg <= HWDATA_I[7:0];
      end
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         cyc_latch_reg <= CYCLE_RST;
      end else if (acc_reg_wr && reg_hit(ap_addr_reg, OFS_CYCLE)) begin
         cyc_latch_reg <= HWDATA_I[11:0];
      end
   end

   // ============================================================
   // Interrupts: a read clears, a new event in that cycle survives
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I || cmd_init) begin
         irq_pend_reg <= 4'h0;
         IRQ_O <= 1'b0;
      end else begin
         if (acc_reg_rd && reg_hit(ap_addr_reg, OFS_IRQ)) begin
            irq_pend_reg <= ev_reg;
         end else begin
            irq_pend_reg <= irq_pend_reg | ev_reg;
         end
         IRQ_O <= |(irq_pend_reg & status_reg[ST_IRQ_LSB +: 4]);
      end
   end

   // ============================================================
   // Frame timer, base tick of 10 us scaled by decades
   assign tick = (presc_reg == 8'(BASE_CYC - 1));
   assign unit_wrap = tick && (unit_reg == units_of(time_word_reg[TW_RATE_LSB +: 3]) - 24'h000001);
   assign frame_done = (state_reg == S_RUN) && unit_wrap && (cnt_reg <= 10'h001);

   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I || state_reg == S_LOAD) begin
         presc_reg <= 8'h00;
         unit_reg <= 24'h000000;
         cnt_reg <= time_word_reg[9:0];
      end else if (state_reg == S_RUN) begin
         presc_reg <= tick ? 8'h00 : presc_reg + 8'h01;
         if (unit_wrap) begin
            unit_reg <= 24'h000000;
            cnt_reg <= cnt_reg - 10'h001;
         end else if (tick) begin
            unit_reg <= unit_reg + 24'h000001;
         end
      end
   end

   // ============================================================
   // Sequencer
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         state_reg <= S_IDLE;
         cyc_cnt_reg <= CYCLE_RST;
         addr_frame_reg <= 10'h000;
         half_reg <= 1'b0;
         time_word_reg <= 16'h0000;
         port_word_reg <= 16'h0000;
         hold_cnt_reg <= 8'h00;
         to_idle_reg <= 1'b0;
         pause_pend_reg <= 1'b0;
         ev_reg <= 4'h0;
         GATE_O <= 1'b0;
         XFER_O <= 1'b1;
         FRAME_O <= 10'h000;
         PORT_O <= 8'h00;
      end else begin
         ev_reg <= 4'h0;
         if ((cmd_pause || hold_edge) && state_reg != S_IDLE) begin
            pause_pend_reg <= 1'b1;
         end
         if (cmd_init && state_reg != S_IDLE && !(state_reg == S_HOLD && to_idle_reg)) begin
            // Drop the gate first so the frame number is held past it
            GATE_O <= 1'b0;
            XFER_O <= 1'b1;
            hold_cnt_reg <= 8'h00;
            to_idle_reg <= 1'b1;
            pause_pend_reg <= 1'b0;
            state_reg <= S_HOLD;
         end else begin
            unique case (state_reg)
               S_IDLE: begin
                  GATE_O <= 1'b0;
                  XFER_O <= 1'b1;
                  pause_pend_reg <= 1'b0;
                  if (start_any) begin
                     cyc_cnt_reg <= cyc_latch_reg;
                     addr_frame_reg <= 10'h000;
                     half_reg <= 1'b0;
                     state_reg <= S_RD_T;
                  end
               end
               S_RD_T: begin
                  state_reg <= S_RD_P;
               end
               S_RD_P: begin
                  time_word_reg <= mem.rdata;
                  state_reg <= S_LOAD;
               end
               S_LOAD: begin
                  port_word_reg <= mem.rdata;
                  GATE_O <= half_reg;
                  XFER_O <= !half_reg;
                  hold_cnt_reg <= 8'h00;
                  to_idle_reg <= 1'b0;
                  state_reg <= S_HOLD;
               end
               S_HOLD: begin
                  if (hold_cnt_reg == 8'(HOLD_CYC - 1)) begin
                     // Frame number only moves here, after the gate edge
                     FRAME_O <= to_idle_reg ? 10'h000 : addr_frame_reg;
                     PORT_O <= to_idle_reg ? 8'h00 : port_word_reg[7:0];
                     if (to_idle_reg) begin
                        state_reg <= S_IDLE;
                     end else if (port_word_reg[PW_PAUSE]) begin
                        ev_reg[EV_PAUSE] <= 1'b1;
                        state_reg <= S_PAUSE;
                     end else begin
                        state_reg <= S_RUN;
                     end
                  end else begin
                     hold_cnt_reg <= hold_cnt_reg + 8'h01;
                  end
               end
               S_RUN: begin
                  if (pause_any && !frame_done) begin
                     pause_pend_reg <= 1'b0;
                     ev_reg[EV_PAUSE] <= 1'b1;
                     state_reg <= S_PAUSE;
                  end else if (frame_done) begin
                     ev_reg[EV_FRAME] <= 1'b1;
                     if (!half_reg) begin
                        half_reg <= 1'b1;
                        state_reg <= S_RD_T;
                     end else if (!port_word_reg[PW_EOL]) begin
                        addr_frame_reg <= addr_frame_reg + 10'h001;
                        half_reg <= 1'b0;
                        state_reg <= S_RD_T;
                     end else if (cyc_cnt_reg != 12'h000) begin
                        cyc_cnt_reg <= cyc_cnt_reg - 12'h001;
                        addr_frame_reg <= 10'h000;
                        half_reg <= 1'b0;
                        ev_reg[EV_CYCLE] <= 1'b1;
                        state_reg <= S_RD_T;
                     end else begin
                        GATE_O <= 1'b0;
                        XFER_O <= 1'b1;
                        hold_cnt_reg <= 8'h00;
                        to_idle_reg <= 1'b1;
                        ev_reg[EV_RUN_END] <= 1'b1;
                        state_reg <= S_HOLD;
                     end
                  end
               end
               S_PAUSE: begin
                  // Timer is frozen here; a start carries on with this frame
                  pause_pend_reg <= 1'b0;
                  if (start_any) begin
                     state_reg <= S_RUN;
                  end
               end
            endcase
         end
      end
   end
endmodule

/* File: testbench/tfoc_top_sva.sv */
/*
   Port checker for the frame controller top.
   Assumes one AHB master with HREADY_I fed from HREADYOUT_O.
*/
`timescale 1ns/1ps
module tfoc_top_sva
   import tfoc_pkg::*;
(
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   // Bus
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic HREADYOUT_O,
   input wire logic HRESP_O,
   // Acquisition outputs
   input wire logic [9:0] FRAME_O,
   input wire logic GATE_O,
   input wire logic XFER_O,
   input wire logic [7:0] PORT_O
);
   // ============================================================
   // Helpers
   logic take;
   logic cmd_ph_reg;
   assign take = HSEL_I && HTRANS_I[1] && HREADY_I && HREADYOUT_O;
   // Marks the data phase of a command write, when HWDATA_I carries the bits
   always_ff @(posedge CLOCK_I) begin
      cmd_ph_reg <= RST_N_I && take && HWRITE_I && (HADDR_I[14:0] == {7'h00, OFS_CMD});
   end
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   // ============================================================
   // Assertions
   AST_XFER_INV: assert property (XFER_O == !GATE_O)
      else $error("transfer strobe not inverse of gate");
   AST_OKAY: assert property (HRESP_O == 1'b0)
      else $error("bus response not okay");
   AST_REG_WAIT: assert property (take && !HADDR_I[MEM_SEL_BIT] |=> !HREADYOUT_O ##1 HREADYOUT_O)
      else $error("register access length wrong");
   AST_MEM_WAIT: assert property (take && HADDR_I[MEM_SEL_BIT] |=> !HREADYOUT_O ##[1:4] HREADYOUT_O)
      else $error("memory access length wrong");
   AST_RDATA_HOLD: assert property (HREADYOUT_O && $past(HREADYOUT_O) |-> $stable(HRDATA_O))
      else $error("read data moved while bus idle");
   AST_FRAME_HOLD: assert property ($fell(GATE_O) |-> $stable(FRAME_O) [*3])
      else $error("frame number changed inside hold time");
   AST_FRAME_EDGE: assert property ($changed(FRAME_O) |-> !GATE_O && !$past(GATE_O, 3))
      else $error("frame number changed outside a boundary");
   AST_INIT_STOP: assert property (cmd_ph_reg && HWDATA_I[CMD_INIT] |=>
      !GATE_O [*3] ##1 (FRAME_O == 10'h000 && PORT_O == 8'h00))
      else $error("initialise did not stop the run");
   // Main scenarios
   cover property (cmd_ph_reg && HWDATA_I[CMD_INIT] && GATE_O);
   cover property ($rose(XFER_O));
   cover property (take && HADDR_I[MEM_SEL_BIT] && !HWRITE_I);
endmodule

bind tfoc_top tfoc_top_sva u_chk (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
   .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .FRAME_O(FRAME_O), .GATE_O(GATE_O), .XFER_O(XFER_O),
   .PORT_O(PORT_O));

/* File: testbench/tfoc_acq_model.sv */
/*
   Downstream acquisition counter model: stores frame and port per strobe.
   Assumes the strobe is only meaningful once reset is released.
*/
`timescale 1ns/1ps
module tfoc_acq_model (
   // Reset
   input wire logic rst_n_i,
   // Link from the controller
   input wire logic xfer_i,
   input wire logic [9:0] frame_i,
   input wire logic [7:0] port_i
);
   logic [17:0] seen [$];
   // The reset edge of the strobe is not a frame end
   always @(posedge xfer_i) begin
      if (rst_n_i === 1'b1) begin
         seen.push_back({frame_i, port_i});
      end
   end
endmodule

/* File: testbench/tb.sv */
/*
   Self-checking bench: AHB-Lite master, external pins, acquisition model.
   Assumes the register map and bit positions of the package.
*/
`timescale 1ns/1ps
module tb;
   import tfoc_pkg::*;
   localparam logic [15:0] A_ST = 16'(OFS_STATUS);
   localparam logic [15:0] A_CM = 16'(OFS_CMD);
   localparam logic [15:0] A_FR = 16'(OFS_FRAME);
   localparam logic [15:0] A_CY = 16'(OFS_CYCLE);
   localparam logic [15:0] A_IQ = 16'(OFS_IRQ);
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic go_n = 1'b1;
   logic hold_n = 1'b1;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, gate, xfer, irq;
   wire logic [9:0] frame;
   wire logic [7:0] port;
   int err_total = 0;
   int comparisons = 0;
   int seed = 32'h41523641;
   int n0;
   logic [31:0] r, d;
   logic [9:0] fr;
   logic [15:0] prog [8] = '{16'h0001, 16'h0011, 16'h0001, 16'h0022, 16'h0001, 16'h0033, 16'h0001, 16'h0044};
   always #20 clk = ~clk;
   tfoc_top DUT (.CLOCK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .EXTERNAL_GO_IN_I(go_n), .EXTERNAL_HOLD_IN_I(hold_n),
      .FRAME_O(frame), .GATE_O(gate), .XFER_O(xfer), .PORT_O(port), .IRQ_O(irq));
   tfoc_acq_model acq (.rst_n_i(rst_n), .xfer_i(xfer), .frame_i(frame), .port_i(port));
   // ============================================================
   // Tasks and expectations
   function automatic logic [31:0] st_exp(input logic [7:0] w);
      return {24'h0, w & 8'hf7};
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] v);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {16'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= v;
      do @(posedge clk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] v);
      bus(1'b1, a, v);
   endtask
   task automatic rd(input logic [15:0] a);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic cmd(input int b);
      wr(A_CM, 32'h1 << b);
   endtask
   task automatic wait_st(input int b, input logic v);
      do rd(A_ST); while (r[b] !== v);
   endtask
   // Pins are pulled low for a few cycles, long enough for the synchroniser
   task automatic pulse(input logic hold);
      if (hold) begin
         hold_n <= 1'b0;
      end else begin
         go_n <= 1'b0;
      end
      repeat (4) @(posedge clk);
      go_n <= 1'b1;
      hold_n <= 1'b1;
   endtask
   task automatic wrap_up;
      if (err_total == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ============================================================
   // Watchdog, well beyond the few thousand cycles the tests need
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      wrap_up;
   end
   // ============================================================
   // Main sequence
   initial begin
      prog[7][PW_EOL] = 1'b1;
      repeat (10) @(posedge clk);
      chk("reset outputs", 32'h00300000, {10'h0, hready, xfer, gate, irq, port, frame});
      rst_n <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 4; i++) begin
         d = $random(seed);
         wr(A_ST, d);
         rd(A_ST);
         chk("status", st_exp(d[7:0]), r & 32'h7f7);
      end
      cmd(CMD_INIT);
      rd(A_ST);
      chk("status after init", 32'h0, r);
      wr(16'h0020, 32'hffffffff);
      rd(16'h0020);
      chk("unmapped", 32'h0, r);
      rd(A_CM);
      chk("command read", 32'h0, r);
      for (int i = 0; i < 5; i++) begin
         d = $random(seed);
         wr(16'h4000 + 16'(4 * (4095 - 977 * i)), d);
         rd(16'h4000 + 16'(4 * (4095 - 977 * i)));
         chk("memory", {16'h0, d[15:0]}, r);
      end
      for (int i = 0; i < 8; i++) begin
         wr(16'h4000 + 16'(4 * i), {16'h0, prog[i]});
      end
      wr(A_CY, 32'hfff);
      rd(A_CY);
      chk("cycle before start", {20'h0, CYCLE_RST}, r);
      cmd(CMD_START);
      repeat (300) @(posedge clk);
      chk("gate in live frame", 32'h1, {31'h0, gate});
      rd(A_CY);
      chk("cycle loaded", 32'hfff, r);
      cmd(CMD_INIT);
      repeat (6) @(posedge clk);
      rd(A_ST);
      chk("status after stop", 32'h0, r & 32'h7ff);
      chk("outputs after stop", 32'h0, {12'h0, gate, irq, port, frame});
      wr(A_CY, 32'h1);
      wr(A_ST, 32'h10);
      n0 = acq.seen.size();
      cmd(CMD_START);
      repeat (100) @(posedge clk);
      cmd(CMD_PAUSE);
      wait_st(ST_PAUSED, 1'b1);
      fr = frame;
      pulse(1'b0);
      repeat (300) @(posedge clk);
      rd(A_ST);
      chk("go ignored", 32'h200, r & 32'h200);
      chk("frame held", {22'h0, fr}, {22'h0, frame});
      rd(A_FR);
      chk("frame read", {22'h0, fr}, r);
      chk("masked irq", 32'h0, {31'h0, irq});
      cmd(CMD_START);
      wait_st(ST_PAUSED, 1'b0);
      wr(A_ST, 32'h13);
      repeat (50) @(posedge clk);
      pulse(1'b1);
      wait_st(ST_PAUSED, 1'b1);
      pulse(1'b0);
      wait_st(ST_PAUSED, 1'b0);
      wait_st(ST_RUN, 1'b0);
      repeat (4) @(posedge clk);
      chk("idle outputs", 32'h0, {12'h0, gate, 1'b0, port, frame});
      rd(A_CY);
      chk("cycle at end", 32'h0, r);
      chk("captures", 32'd4, 32'(acq.seen.size() - n0));
      for (int i = 0; i < 4; i++) begin
         chk("port at strobe", {24'h0, prog[4 * (i % 2) + 3][7:0]}, {24'h0, acq.seen[n0 + i][7:0]});
      end
      chk("first frame", 32'h0, {22'h0, acq.seen[n0][17:8]});
      chk("irq raised", 32'h1, {31'h0, irq});
      rd(A_IQ);
      chk("run end pending", 32'h10, r & 32'h10);
      repeat (3) @(posedge clk);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // Pause bit in the first dead port word pauses the run after loading it
      wr(16'h4004, 32'h4011);
      cmd(CMD_START);
      wait_st(ST_PAUSED, 1'b1);
      chk("paused outputs", 32'h11, {23'h0, gate, port});
      cmd(CMD_INIT);
      wait_st(ST_RUN, 1'b0);
      wrap_up;
   end
endmodule
